// [irtdc_pkg.sv]
// irtdc_pkg: constants, enums and state carriers for the ir timer pair
// common control and demodulation block.
// assumes: one 100 MHz clock, register reached through bank d pointer.
package irtdc_pkg;

  // register placement: bank selected by pointer low nibble, then offset
  localparam logic [3:0] CTRL_BANK = 4'hD;
  localparam logic [3:0] CTRL_OFFSET = 4'h1;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // field positions inside timer_pair_common_control
  localparam int MODE_BIT = 7;
  localparam int PIN_BIT = 6;
  localparam int EDGE_HI = 5;
  localparam int EDGE_LO = 4;
  localparam int SUB_HI = 3;
  localparam int SUB_LO = 2;
  localparam int B1_BIT = 1;
  localparam int B0_BIT = 0;

  // glitch filter lengths in clock cycles
  localparam logic [3:0] FILT_SHORT = 4'h4;
  localparam logic [3:0] FILT_LONG = 4'h8;

  localparam logic [7:0] SHORT_ALL_ONES = 8'hFF;
  localparam logic [7:0] SHORT_ZERO = 8'h00;
  localparam logic [15:0] LONG_ZERO = 16'h0000;

  typedef enum logic [1:0] {
    IRTDC_TX_NORMAL = 2'b00,
    IRTDC_TX_PINGPONG = 2'b01,
    IRTDC_TX_LONG_LOW = 2'b10,
    IRTDC_TX_LONG_HIGH = 2'b11
  } irtdc_submode_e;

  typedef enum logic [1:0] {
    IRTDC_FILT_NONE = 2'b00,
    IRTDC_FILT_4 = 2'b01,
    IRTDC_FILT_8 = 2'b10,
    IRTDC_FILT_RSVD = 2'b11
  } irtdc_filter_e;

  typedef enum logic [1:0] {
    IRTDC_EDGE_NONE = 2'b00,
    IRTDC_EDGE_RISE = 2'b01,
    IRTDC_EDGE_FALL = 2'b10,
    IRTDC_EDGE_BOTH = 2'b11
  } irtdc_edge_e;

  // software-visible control fields
  typedef struct packed {
    logic mode;
    logic pin_sel;
    logic [1:0] edge_sel;
    logic [1:0] sub;
    logic init_short;
    logic init_long;
    logic rise_flag;
    logic fall_flag;
  } irtdc_ctrl_s;

  // outputs of the short/long timer pair
  typedef struct packed {
    logic short_out;
    logic long_out;
    logic short_en;
    logic long_en;
    logic short_timeout;
    logic long_timeout;
  } irtdc_tmr_s;

endpackage : irtdc_pkg

// [irtdc_glitch_filter.sv]
// irtdc_glitch_filter: passes a level once it has held for a set count.
// assumes: input already synchronised to mclk; len of zero means bypass.
`timescale 1ns/1ps
module irtdc_glitch_filter (
  input wire logic mclk,
  input wire logic reset,
  input wire logic din,
  input wire logic [3:0] len,
  output logic dout
);

  typedef struct packed {
    logic level;
    logic [3:0] cnt;
  } irtdc_filt_s;

  irtdc_filt_s state;
  irtdc_filt_s next_state;

  // count cycles the input differs from the output; any bounce restarts
  always_comb begin
    next_state = state;
    if (len == 4'h0) begin
      next_state.level = din;
      next_state.cnt = 4'h0;
    end else if (din == state.level) begin
      next_state.cnt = 4'h0;
    end else if (state.cnt + 4'h1 >= len) begin
      next_state.level = din;
      next_state.cnt = 4'h0;
    end else begin
      next_state.cnt = state.cnt + 4'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign dout = state.level;

endmodule : irtdc_glitch_filter

// [irtdc_core.sv]
// irtdc_core: common control register, transmit output logic and
// demodulation capture for an 8-bit short timer and 16-bit long timer.
// assumes: register reached by bank pointer plus 4-bit offset; reload
// counts arrive from the per-timer registers held elsewhere.
//
// Overview of operation
// [R01] mode field zero is transmit, else demodulation
// [R02] transmit: pin bit picks port or combined output
// [R03] demodulation: pin bit picks input pin a/b
// [R04] pin b capture also raises its interrupt
// [R05] software masks that interrupt or uses pin a
// [R06] bits 3-2: submode in transmit, filter in demod
// [R07] bit 1 sets initial short output level
// [R08] bit 0 sets initial long output level
// [R09] wrap from zero to all ones: no timeout
// [R10] software events act one counter tick later
// [R11] software stops timers, then clears status separately
// [R12] software loads both short reloads with all ones
// [R13] short timer starts on first qualifying edge
// [R14] later edges capture complemented short count
// [R15] edge polarity picks the capture register
// [R16] power-on defaults; stop recovery keeps control fields
// [R17] demod bits 1-0 are edge flags, write-1-clear
// [R18] ping-pong alternates short and long enables
// [R19] ping-pong sets timeout at each terminal count
`timescale 1ns/1ps
module irtdc_core #(
  parameter int TICK_DIV = 1
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic stop_recovery,
  input wire logic [3:0] rp_bank,
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic short_start,
  input wire logic long_start,
  input wire logic timer_stop,
  input wire logic [7:0] short_timer_low_count,
  input wire logic [7:0] short_timer_high_count,
  input wire logic [15:0] long_reload,
  input wire logic port_output_value,
  input wire logic demod_input_pin_a,
  input wire logic demod_input_pin_b,
  output logic combined_output_pin,
  output irtdc_pkg::irtdc_tmr_s timers,
  output logic [7:0] pos_capture,
  output logic [7:0] neg_capture,
  output logic capture_pin_interrupt
);

  typedef struct packed {
    irtdc_pkg::irtdc_ctrl_s ctrl;
    irtdc_pkg::irtdc_tmr_s tmr;
    logic [7:0] short_cnt;
    logic [15:0] long_cnt;
    logic counting;
    logic pend_short;
    logic pend_long;
    logic pend_stop;
    logic [7:0] pos_cap;
    logic [7:0] neg_cap;
    logic irq;
    logic [7:0] rdata;
    logic [1:0] sync_a;
    logic [1:0] sync_b;
    logic filt_prev;
    logic [7:0] tick_cnt;
  } irtdc_state_s;

  irtdc_state_s state;
  irtdc_state_s next_state;
  logic filt_out;
  logic [3:0] filt_len;
  logic sel_in;

  // selected pin only after both synchroniser stages
  assign sel_in = state.ctrl.pin_sel ? state.sync_b[1] : state.sync_a[1]; // [R03]

  // filter length from bits 3-2 while demodulating; reserved code bypasses
  always_comb begin
    filt_len = 4'h0;
    if (state.ctrl.mode) begin
      unique case (irtdc_pkg::irtdc_filter_e'(state.ctrl.sub)) // [R06]
        irtdc_pkg::IRTDC_FILT_NONE: filt_len = 4'h0;
        irtdc_pkg::IRTDC_FILT_4: filt_len = irtdc_pkg::FILT_SHORT;
        irtdc_pkg::IRTDC_FILT_8: filt_len = irtdc_pkg::FILT_LONG;
        irtdc_pkg::IRTDC_FILT_RSVD: filt_len = 4'h0;
      endcase
    end
  end

  irtdc_glitch_filter u_filter (
    .mclk(mclk),
    .reset(reset),
    .din(sel_in),
    .len(filt_len),
    .dout(filt_out)
  );

  function automatic logic edge_ok(input logic [1:0] sel, input logic rise);
    edge_ok = rise ? sel[0] : sel[1];
  endfunction : edge_ok

  // next-state logic: register access, tick-aligned timers, capture
  always_comb begin
    logic sel_hit;
    logic tick;
    logic rise;
    logic fall;
    logic qual;
    logic pingpong;
    sel_hit = 1'b0;
    tick = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    qual = 1'b0;
    pingpong = 1'b0;
    next_state = state;
    next_state.tmr.short_timeout = 1'b0;
    next_state.tmr.long_timeout = 1'b0;
    next_state.irq = 1'b0;
    next_state.sync_a = {state.sync_a[0], demod_input_pin_a};
    next_state.sync_b = {state.sync_b[0], demod_input_pin_b};
    next_state.filt_prev = filt_out;

    // counter clock divider: one-cycle tick every TICK_DIV cycles
    if (state.tick_cnt >= 8'(TICK_DIV - 1)) begin
      next_state.tick_cnt = 8'h00;
      tick = 1'b1;
    end else begin
      next_state.tick_cnt = state.tick_cnt + 8'h01;
    end

    sel_hit = (rp_bank == irtdc_pkg::CTRL_BANK) &&
              (reg_addr == irtdc_pkg::CTRL_OFFSET);
    pingpong = !state.ctrl.mode &&
               (state.ctrl.sub == 2'(irtdc_pkg::IRTDC_TX_PINGPONG));

    if (tick) begin
      next_state.pend_short = 1'b0;
      next_state.pend_long = 1'b0;
      next_state.pend_stop = 1'b0;
      if (state.pend_stop) begin
        next_state.tmr.short_en = 1'b0;
        next_state.tmr.long_en = 1'b0;
        next_state.counting = 1'b0;
      end
      if (state.pend_short && !state.pend_stop) begin
        next_state.tmr.short_en = 1'b1;
        next_state.counting = 1'b0;
        if (!state.ctrl.mode) begin
          next_state.tmr.short_out = state.ctrl.init_short; // [R07]
          next_state.short_cnt = state.ctrl.init_short ?
            short_timer_high_count : short_timer_low_count;
        end
      end
      if (state.pend_long && !state.pend_stop && !state.ctrl.mode) begin
        next_state.tmr.long_en = 1'b1;
        next_state.tmr.long_out = state.ctrl.init_long; // [R08]
        next_state.long_cnt = long_reload;
      end

      // transmit: terminal count reloads and toggles, never wraps
      if (!state.ctrl.mode && state.tmr.short_en && !state.pend_stop) begin
        if (state.short_cnt == irtdc_pkg::SHORT_ZERO) begin
          next_state.tmr.short_timeout = 1'b1; // [R19]
          next_state.tmr.short_out = !state.tmr.short_out;
          next_state.short_cnt = state.tmr.short_out ?
            short_timer_low_count : short_timer_high_count;
          if (pingpong) begin
            next_state.tmr.short_en = 1'b0; // [R18]
            next_state.tmr.long_en = 1'b1; // [R18]
            next_state.long_cnt = long_reload;
          end
        end else begin
          next_state.short_cnt = state.short_cnt - 8'h01;
        end
      end
      if (!state.ctrl.mode && state.tmr.long_en && !state.pend_stop) begin
        if (state.long_cnt == irtdc_pkg::LONG_ZERO) begin
          next_state.tmr.long_timeout = 1'b1; // [R19]
          next_state.tmr.long_out = !state.tmr.long_out;
          next_state.long_cnt = long_reload;
          if (pingpong) begin
            next_state.tmr.long_en = 1'b0; // [R18]
            next_state.tmr.short_en = 1'b1; // [R18]
            next_state.short_cnt = state.tmr.short_out ?
              short_timer_high_count : short_timer_low_count;
          end
        end else begin
          next_state.long_cnt = state.long_cnt - 16'h0001;
        end
      end

      // demod: free count down; 0 to all ones is silent wrap
      if (state.ctrl.mode && state.counting && !state.pend_stop) begin
        next_state.short_cnt = state.short_cnt - 8'h01; // [R09]
      end
    end

    // requests latch after the tick clear, so one taken on a tick survives
    if (short_start) next_state.pend_short = 1'b1; // [R10]
    if (long_start) next_state.pend_long = 1'b1; // [R10]
    if (timer_stop) next_state.pend_stop = 1'b1; // [R10]

    // submodes that pin the long output override its toggling
    if (!state.ctrl.mode &&
        state.ctrl.sub == 2'(irtdc_pkg::IRTDC_TX_LONG_LOW)) begin
      next_state.tmr.long_out = 1'b0; // [R06]
    end
    if (!state.ctrl.mode &&
        state.ctrl.sub == 2'(irtdc_pkg::IRTDC_TX_LONG_HIGH)) begin
      next_state.tmr.long_out = 1'b1; // [R06]
    end

    // demod edges: flags, start on first, capture afterwards
    rise = filt_out && !state.filt_prev;
    fall = !filt_out && state.filt_prev;
    qual = (rise && edge_ok(state.ctrl.edge_sel, 1'b1)) ||
           (fall && edge_ok(state.ctrl.edge_sel, 1'b0));

    // write-1-clear first, so a same-cycle edge sets again
    if (reg_wr && sel_hit) begin
      next_state.ctrl.mode = reg_wdata[irtdc_pkg::MODE_BIT]; // [R01]
      next_state.ctrl.pin_sel = reg_wdata[irtdc_pkg::PIN_BIT];
      next_state.ctrl.edge_sel =
        reg_wdata[irtdc_pkg::EDGE_HI:irtdc_pkg::EDGE_LO];
      next_state.ctrl.sub = reg_wdata[irtdc_pkg::SUB_HI:irtdc_pkg::SUB_LO];
      if (state.ctrl.mode) begin
        if (reg_wdata[irtdc_pkg::B1_BIT]) next_state.ctrl.rise_flag = 1'b0; // [R17]
        if (reg_wdata[irtdc_pkg::B0_BIT]) next_state.ctrl.fall_flag = 1'b0; // [R17]
      end else begin
        next_state.ctrl.init_short = reg_wdata[irtdc_pkg::B1_BIT]; // [R07]
        next_state.ctrl.init_long = reg_wdata[irtdc_pkg::B0_BIT]; // [R08]
      end
    end

    if (state.ctrl.mode) begin
      if (rise && edge_ok(state.ctrl.edge_sel, 1'b1)) begin
        next_state.ctrl.rise_flag = 1'b1; // [R17]
      end
      if (fall && edge_ok(state.ctrl.edge_sel, 1'b0)) begin
        next_state.ctrl.fall_flag = 1'b1; // [R17]
      end
      if (qual && state.tmr.short_en) begin
        if (!state.counting) begin
          next_state.counting = 1'b1; // [R13]
          next_state.short_cnt = short_timer_low_count;
        end else begin
          if (rise) next_state.pos_cap = ~state.short_cnt; // [R14] [R15]
          else next_state.neg_cap = ~state.short_cnt; // [R14] [R15]
          next_state.irq = state.ctrl.pin_sel; // [R04]
        end
      end
    end

    // stop recovery halts counting but keeps every control field
    if (stop_recovery) begin
      next_state.tmr.short_en = 1'b0; // [R16]
      next_state.tmr.long_en = 1'b0;
      next_state.counting = 1'b0;
      next_state.ctrl = state.ctrl; // [R16]
    end

    // read data: bits 1-0 show flags while demodulating
    if (reg_rd && sel_hit) begin
      next_state.rdata = {state.ctrl.mode, state.ctrl.pin_sel,
        state.ctrl.edge_sel, state.ctrl.sub,
        state.ctrl.mode ? state.ctrl.rise_flag : state.ctrl.init_short,
        state.ctrl.mode ? state.ctrl.fall_flag : state.ctrl.init_long};
    end
  end

  // power-on reset loads control defaults
  always_ff @(posedge mclk) begin
    if (reset) begin
      state <= '0;
      state.ctrl <= irtdc_pkg::irtdc_ctrl_s'({2'b00,
        irtdc_pkg::CTRL_RESET}); // [R16]
    end else begin
      state <= next_state;
    end
  end

  // pin carries port data or the combined timer output
  assign combined_output_pin = (!state.ctrl.mode && state.ctrl.pin_sel) ?
    (state.tmr.short_out ^ state.tmr.long_out) : port_output_value; // [R02]
  assign timers = state.tmr;
  assign pos_capture = state.pos_cap;
  assign neg_capture = state.neg_cap;
  assign capture_pin_interrupt = state.irq;
  assign reg_rdata = state.rdata;

endmodule : irtdc_core

// [irtdc_core_chk.sv]
// irtdc_core_chk: port-level assertions for irtdc_core.
// assumes: bound from tb_top, tick divider left at 1.
`timescale 1ns/1ps
module irtdc_core_chk (
  input wire logic mclk,
  input wire logic reset,
  input wire logic short_start,
  input wire logic timer_stop,
  input wire logic port_output_value,
  input wire logic combined_output_pin,
  input wire irtdc_pkg::irtdc_tmr_s timers,
  input wire logic [7:0] pos_capture,
  input wire logic [7:0] neg_capture,
  input wire logic capture_pin_interrupt
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // software events wait one tick, never zero
  a_start_late: assert property (
    short_start && !timer_stop && !timers.short_en |=> !timers.short_en)
    else $error("short timer enabled too early");
  a_start_lands: assert property (
    short_start && !timer_stop ##1 !timer_stop |=> timers.short_en)
    else $error("short timer start lost");
  // stop wins and lands two edges after the strobe
  a_stop_lands: assert property (
    timer_stop |-> ##2 !(timers.short_en || timers.long_en))
    else $error("timers still enabled after stop");
  // a timeout only comes from a running counter
  a_short_tout: assert property (
    timers.short_timeout |-> $past(timers.short_en))
    else $error("short timeout while disabled");
  a_long_tout: assert property (
    timers.long_timeout |-> $past(timers.long_en))
    else $error("long timeout while disabled");
  a_irq_pulse: assert property (
    capture_pin_interrupt |=> !capture_pin_interrupt)
    else $error("capture interrupt longer than one cycle");
  // captures move only while the short timer counts
  a_cap_hold: assert property (
    !timers.short_en |=> $stable(pos_capture) && $stable(neg_capture))
    else $error("capture changed with timer idle");
  // both pin sources agree, so the mux choice cannot matter
  a_pin_low: assert property (
    timers.short_out == timers.long_out && !port_output_value
      |-> !combined_output_pin)
    else $error("shared pin high with both sources low");
  a_pin_high: assert property (
    timers.short_out != timers.long_out && port_output_value
      |-> combined_output_pin)
    else $error("shared pin low with both sources high");
  c_tout: cover property (timers.short_timeout);
  c_irq: cover property (capture_pin_interrupt);
  c_cap: cover property (timers.short_en ##1 $changed(neg_capture));
endmodule : irtdc_core_chk

// [irtdc_ir_src.sv]
// irtdc_ir_src: behavioural infrared receiver on the demod pins.
// assumes: go is a one-cycle pulse; idle line level is low.
`timescale 1ns/1ps
module irtdc_ir_src #(
  parameter int HI = 20
) (
  input wire logic mclk,
  input wire logic go,
  input wire logic sel_b,
  output logic pin_a,
  output logic pin_b
);
  int cnt = 0;
  logic lvl = 1'b0;
  // one high burst of HI cycles per go, giving a rise and a fall
  always @(posedge mclk) begin
    if (go) begin
      cnt <= HI;
      lvl <= 1'b1;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else begin
      lvl <= 1'b0;
    end
  end
  // only the selected pin carries the burst
  assign pin_a = lvl & !sel_b;
  assign pin_b = lvl & sel_b;
endmodule : irtdc_ir_src

// [tb_top.sv]
// tb_top: directed bench for irtdc_core with an ir source model.
// assumes: irtdc_core_chk and irtdc_ir_src compiled before this file.
`timescale 1ns/1ps
module tb_top;
  logic mclk, reset, stop_recovery, reg_wr, reg_rd, go, sel_b;
  logic short_start, long_start, timer_stop, port_output_value;
  logic pin_a, pin_b, combined_output_pin, capture_pin_interrupt;
  logic [3:0] rp_bank, reg_addr;
  logic [7:0] reg_wdata, reg_rdata, low, high, pos_capture, neg_capture, rv;
  logic [15:0] long_reload;
  irtdc_pkg::irtdc_tmr_s timers;
  int failures = 0;
  int checks_done = 0;
  int irq_cnt = 0;

  // free-running 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  irtdc_core irtdc_core_i (.mclk(mclk), .reset(reset),
    .stop_recovery(stop_recovery), .rp_bank(rp_bank), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .short_start(short_start),
    .long_start(long_start), .timer_stop(timer_stop),
    .short_timer_low_count(low), .short_timer_high_count(high),
    .long_reload(long_reload), .port_output_value(port_output_value),
    .demod_input_pin_a(pin_a), .demod_input_pin_b(pin_b),
    .combined_output_pin(combined_output_pin), .timers(timers),
    .pos_capture(pos_capture), .neg_capture(neg_capture),
    .capture_pin_interrupt(capture_pin_interrupt));

  irtdc_ir_src irtdc_ir_src_i (.mclk(mclk), .go(go), .sel_b(sel_b),
    .pin_a(pin_a), .pin_b(pin_b));

  // interrupt pulses are one cycle, so count them at every edge
  always @(posedge mclk) if (capture_pin_interrupt === 1'b1) irq_cnt++;

  task summarize;
    $display("checks_done=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  task chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  task chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask : chk1

  // inputs always move 1 ns after the rising edge
  task tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  task wr(input logic [3:0] b, input logic [3:0] a, input logic [7:0] d);
    rp_bank = b;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
  endtask : wr

  task rd(input logic [3:0] a, output logic [7:0] d);
    rp_bank = 4'hD;
    reg_addr = a;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    tick(1);
    d = reg_rdata;
  endtask : rd

  // m is {short_start, long_start, timer_stop}
  task ev(input logic [2:0] m);
    {short_start, long_start, timer_stop} = m;
    tick(1);
    {short_start, long_start, timer_stop} = 3'h0;
  endtask : ev

  task burst(input logic s);
    sel_b = s;
    go = 1'b1;
    tick(1);
    go = 1'b0;
    tick(40);
  endtask : burst

  function automatic logic hit(input int k);
    return k == 0 ? timers.short_timeout :
      k == 1 ? timers.long_timeout : timers.long_en;
  endfunction : hit

  // bounded wait; running out ends the run as a mismatch
  task waitfor(input int k, input int lim);
    int n;
    n = 0;
    checks_done++;
    while (hit(k) !== 1'b1) begin
      if (n == lim) begin
        failures++;
        summarize();
      end else begin
        n++;
        tick(1);
      end
    end
  endtask : waitfor

  initial begin
    reset = 1'b1;
    {stop_recovery, reg_wr, reg_rd, go, sel_b} = 5'h00;
    {short_start, long_start, timer_stop, port_output_value} = 4'h0;
    rp_bank = 4'h0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    low = 8'h03;
    high = 8'h03;
    long_reload = 16'h0006;
    tick(3);
    reset = 1'b0;
    // register access, decode and stop recovery
    rd(4'h1, rv);
    chk8(rv, irtdc_pkg::CTRL_RESET);
    wr(4'hD, 4'h1, 8'h43);
    rd(4'h1, rv);
    chk8(rv, 8'h43);
    wr(4'h0, 4'h1, 8'hFF);
    wr(4'hD, 4'h2, 8'hFF);
    rd(4'h2, rv);
    chk8(rv, 8'h43);
    stop_recovery = 1'b1;
    tick(1);
    stop_recovery = 1'b0;
    rd(4'h1, rv);
    chk8(rv, 8'h43);
    // forced long output levels and plain port path
    port_output_value = 1'b1;
    wr(4'hD, 4'h1, 8'h0C);
    tick(2);
    chk1(timers.long_out, 1'b1);
    chk1(combined_output_pin, 1'b1);
    wr(4'hD, 4'h1, 8'h08);
    tick(2);
    chk1(timers.long_out, 1'b0);
    // normal transmit, then stop
    wr(4'hD, 4'h1, 8'h40);
    ev(3'h6);
    waitfor(0, 30);
    waitfor(1, 60);
    ev(3'h1);
    tick(1);
    chk1(timers.short_en | timers.long_en, 1'b0);
    // ping-pong hands the run to the long timer
    wr(4'hD, 4'h1, 8'h44);
    ev(3'h4);
    waitfor(2, 40);
    ev(3'h1);
    tick(2);
    // demodulation on pin a, both edges
    low = 8'hFF;
    high = 8'hFF;
    wr(4'hD, 4'h1, 8'hB0);
    ev(3'h4);
    burst(1'b0);
    chk1(neg_capture >= 8'h12 && neg_capture <= 8'h16, 1'b1);
    chk8(pos_capture, 8'h00);
    rd(4'h1, rv);
    chk8(rv, 8'hB3);
    wr(4'hD, 4'h1, 8'hB7);
    rd(4'h1, rv);
    chk8(rv, 8'hB4);
    burst(1'b0);
    chk1(pos_capture != 8'h00, 1'b1);
    chk8(irq_cnt[7:0], 8'h00);
    ev(3'h1);
    tick(2);
    // pin b with the 8-cycle filter raises the pin interrupt
    wr(4'hD, 4'h1, 8'hF8);
    ev(3'h4);
    burst(1'b1);
    chk1(irq_cnt != 0, 1'b1);
    summarize();
  end
endmodule : tb_top

bind irtdc_core irtdc_core_chk irtdc_core_chk_i (.mclk(mclk), .reset(reset),
  .short_start(short_start), .timer_stop(timer_stop),
  .port_output_value(port_output_value),
  .combined_output_pin(combined_output_pin), .timers(timers),
  .pos_capture(pos_capture), .neg_capture(neg_capture),
  .capture_pin_interrupt(capture_pin_interrupt));
